// file: verilog/rtmr_top.v
/*
 * radio timer control: absolute clock, three one-shot match timers,
 * enable/disable/abort registers and an interrupt.
 * assumes a strobe register port on core_clk; rx pins are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rtmr_consts.vh"

module rtmr_top #(
    parameter TICK_CYCLES = `RTMR_TICK_CYCLES
) (
    input  wire        core_clk,
    input  wire        rst_n,
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata_ff,
    input  wire [31:0] start_trigger,
    input  wire [31:0] cpl_trigger,
    input  wire [31:0] soft_trigger,
    input  wire [31:0] rel_time,
    input  wire        rx_sfd_seen,
    input  wire        rx_done,
    output reg  [31:0] absolute_time_value_ff,
    output reg  [2:0]  timer_status_ff,
    output reg         start_proceed_ff,
    output reg         cpl_event_ff,
    output reg         soft_event_ff,
    output reg         timeout_event_ff,
    output reg         action_started_interrupt_ff,
    output reg         irq_ff
);

    // ==========================================
    // decode
    function is_wr;
        input [7:0] ofs;
        begin
            is_wr = reg_wr && (reg_addr == ofs);
        end
    endfunction

    wire wr_en   = is_wr(`RTMR_OFS_ENABLE);
    wire wr_dis  = is_wr(`RTMR_OFS_DISABLE);
    wire wr_clk  = is_wr(`RTMR_OFS_ABS_CLK);
    wire wr_stat = is_wr(`RTMR_OFS_IRQ_STAT);
    wire wr_mask = is_wr(`RTMR_OFS_IRQ_MASK);
    wire wr_ctrl = is_wr(`RTMR_OFS_CTRL);

    // ==========================================
    // pin synchronisers
    reg [2:0] sfd_sync_ff;
    reg [2:0] done_sync_ff;
    reg       sfd_ff;
    reg       done_ff;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sfd_sync_ff  <= 3'h0;
            done_sync_ff <= 3'h0;
            sfd_ff       <= 1'b0;
            done_ff      <= 1'b0;
        end else begin
            sfd_sync_ff  <= {sfd_sync_ff[1:0], rx_sfd_seen};
            done_sync_ff <= {done_sync_ff[1:0], rx_done};
            if (sfd_sync_ff[1] == sfd_sync_ff[2]) begin
                sfd_ff <= sfd_sync_ff[2];
            end
            if (done_sync_ff[1] == done_sync_ff[2]) begin
                done_ff <= done_sync_ff[2];
            end
        end
    end

    // frame in flight between delimiter and completion
    reg in_frame_ff;
    reg sfd_d_ff;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_frame_ff <= 1'b0;
            sfd_d_ff    <= 1'b0;
        end else begin
            sfd_d_ff <= sfd_ff;
            if (done_ff) begin
                in_frame_ff <= 1'b0;
            end else if (sfd_ff && !sfd_d_ff) begin
                in_frame_ff <= 1'b1;
            end
        end
    end

    // ==========================================
    // absolute clock
    reg [15:0] pre_ff;
    reg        tick_ff;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_ff                 <= 16'h0;
            tick_ff                <= 1'b0;
            absolute_time_value_ff <= `RTMR_RST_ABS_CLK;
        end else begin
            tick_ff <= 1'b0;
            if (wr_clk) begin
                pre_ff                 <= 16'h0;
                absolute_time_value_ff <= reg_wdata; // RQ9
            end else if (pre_ff == TICK_CYCLES[15:0] - 16'h1) begin
                pre_ff                 <= 16'h0;
                tick_ff                <= 1'b1;
                absolute_time_value_ff <= absolute_time_value_ff + 32'h1; // RQ8
            end else begin
                pre_ff <= pre_ff + 16'h1;
            end
        end
    end

    // ==========================================
    // timers
    reg         sel_rel_ff;
    wire [31:0] cmp_time = sel_rel_ff ? rel_time : absolute_time_value_ff;
    wire [2:0]  fire;
    wire [2:0]  hold = {in_frame_ff, 2'b00};
    wire [95:0] trig = {soft_trigger, cpl_trigger, start_trigger};

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_tmr
            rtmr_match u_match (
                .core_clk (core_clk),
                .rst_n    (rst_n),
                .armed    (timer_status_ff[g]),
                .tick     (tick_ff),
                .trigger  (trig[g*32 +: 32]),
                .cmp_time (cmp_time),
                .hold     (hold[g]),
                .fire_ff  (fire[g])
            );
        end
    endgenerate

    wire [2:0] abort_req = wr_dis ? reg_wdata[5:3] : 3'h0; // RQ6
    wire       abort_hit = |(abort_req & timer_status_ff); // RQ7
    reg  [2:0] nxt_status;

    always @* begin
        nxt_status = timer_status_ff;
        nxt_status = nxt_status & ~{fire[2:1], fire[0]}; // RQ13
        if (wr_dis) begin
            nxt_status = nxt_status & ~reg_wdata[2:0] & ~reg_wdata[5:3]; // RQ4 RQ5
        end
        if (wr_en) begin
            nxt_status = nxt_status | reg_wdata[2:0]; // RQ1 RQ2
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_status_ff             <= `RTMR_RST_ENABLE;
            sel_rel_ff                  <= 1'b0;
            start_proceed_ff            <= 1'b0;
            cpl_event_ff                <= 1'b0;
            soft_event_ff               <= 1'b0;
            timeout_event_ff            <= 1'b0;
            action_started_interrupt_ff <= 1'b0;
        end else begin
            timer_status_ff             <= nxt_status;
            start_proceed_ff            <= fire[`RTMR_BIT_START]; // RQ13
            action_started_interrupt_ff <= fire[`RTMR_BIT_START]; // RQ13
            cpl_event_ff                <= fire[`RTMR_BIT_CPL];
            soft_event_ff               <= fire[`RTMR_BIT_SOFT];
            timeout_event_ff            <= abort_hit; // RQ7
            if (wr_ctrl) begin
                sel_rel_ff <= reg_wdata[`RTMR_BIT_SEL]; // RQ12
            end
        end
    end

    // ==========================================
    // interrupt status and mask
    reg  [3:0] irq_stat_ff;
    reg  [3:0] irq_mask_ff;
    wire [3:0] irq_set = {fire[2], fire[1], abort_hit, fire[0]};
    wire [3:0] nxt_irq_stat = (irq_stat_ff & ~(wr_stat ? reg_wdata[3:0] : 4'h0)) | irq_set;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_ff <= 4'h0;
            irq_mask_ff <= 4'h0;
            irq_ff      <= 1'b0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            if (wr_mask) begin
                irq_mask_ff <= reg_wdata[3:0];
            end
            irq_ff <= |(nxt_irq_stat & (wr_mask ? reg_wdata[3:0] : irq_mask_ff));
        end
    end

    // ==========================================
    // read back
    reg [31:0] nxt_rdata;

    always @* begin
        nxt_rdata = 32'h0;
        case (reg_addr)
            `RTMR_OFS_ENABLE:   nxt_rdata = {29'h0, timer_status_ff}; // RQ3 RQ15
            `RTMR_OFS_DISABLE:  nxt_rdata = {29'h0, timer_status_ff}; // RQ3 RQ15
            `RTMR_OFS_ABS_CLK:  nxt_rdata = absolute_time_value_ff; // RQ10
            `RTMR_OFS_IRQ_STAT: nxt_rdata = {28'h0, irq_stat_ff};
            `RTMR_OFS_IRQ_MASK: nxt_rdata = {28'h0, irq_mask_ff};
            `RTMR_OFS_CTRL:     nxt_rdata = {31'h0, sel_rel_ff};
            default:            nxt_rdata = 32'h0;
        endcase
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_ff <= 32'h0;
        end else begin
            reg_rdata_ff <= reg_rd ? nxt_rdata : 32'h0;
        end
    end

endmodule

`default_nettype wire

// file: verilog/rtmr_consts.vh
/*
 * constants for the radio timer block: register offsets, field positions,
 * reset values and tick timing.
 * assumes a 125 MHz core clock and a plain strobe register port.
 */
// Operation
// RQ1: a one written to bit 2, 1 or 0 of the enable register enables the soft complete, complete or start timer.
// RQ2: the enable register touches only timers whose written bit is one.
// RQ3: reading the enable or disable register returns the live enabled status of each timer.
// RQ4: a one written to bit 2, 1 or 0 of the disable register disables the soft complete, complete or start timer.
// RQ5: the disable register touches only timers whose written bit is one.
// RQ6: a one written to bit 5, 4 or 3 of the disable register stops the running soft complete, complete or start timer at once.
// RQ7: aborting an armed timer also raises a time-out event toward the sequencer.
// RQ8: a free-running 32-bit absolute time counter advances at 250 kHz.
// RQ9: writing the absolute clock register loads the new time and counting goes on from there.
// RQ10: reading the absolute clock register returns the live counter value.
// RQ11: software keeps all timers idle while it loads a new absolute time.
// RQ12: each enabled timer compares its trigger against the absolute or the relative clock as a select chooses.
// RQ13: a start timer match raises the action started interrupt, disables the timer and tells the sequencer to go on.
// RQ14: a soft complete match seen after a frame delimiter waits until reception ends or the frame is dropped; the code ends the wait only on rx_done.
// RQ15: reserved bits of the enable, disable and clock registers read zero and ignore writes.
`ifndef RTMR_CONSTS_VH
`define RTMR_CONSTS_VH

// ==========================================
// register offsets
`define RTMR_OFS_ENABLE     8'h40
`define RTMR_OFS_DISABLE    8'h44
`define RTMR_OFS_ABS_CLK    8'h48
`define RTMR_OFS_IRQ_STAT   8'h60
`define RTMR_OFS_IRQ_MASK   8'h64
`define RTMR_OFS_CTRL       8'h68

// ==========================================
// field positions
`define RTMR_BIT_START      0
`define RTMR_BIT_CPL        1
`define RTMR_BIT_SOFT       2
`define RTMR_BIT_ABORT_LSB  3
`define RTMR_BIT_SEL        0
`define RTMR_IRQ_STARTED    0
`define RTMR_IRQ_TIMEOUT    1
`define RTMR_IRQ_CPL        2
`define RTMR_IRQ_SOFT       3

// ==========================================
// reset values
`define RTMR_RST_ENABLE     3'h0
`define RTMR_RST_ABS_CLK    32'h0

// ==========================================
// timing
`define RTMR_CLK_HZ         125000000
`define RTMR_TICK_HZ        250000
`define RTMR_TICK_CYCLES    (`RTMR_CLK_HZ / `RTMR_TICK_HZ)

`endif

// file: verilog/rtmr_match.v
/*
 * one-shot match timer: compares a trigger against the selected clock.
 * assumes all inputs are on core_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module rtmr_match (
    input  wire        core_clk,
    input  wire        rst_n,
    input  wire        armed,
    input  wire        tick,
    input  wire [31:0] trigger,
    input  wire [31:0] cmp_time,
    input  wire        hold,
    output reg         fire_ff
);

    // ==========================================
    // match and postpone
    reg hit_ff;
    reg nxt_hit;

    always @* begin
        nxt_hit = hit_ff;
        if (!armed) begin
            nxt_hit = 1'b0;
        end else if (tick && cmp_time == trigger) begin
            nxt_hit = 1'b1; // RQ12
        end
        if (fire_ff) begin
            nxt_hit = 1'b0;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hit_ff  <= 1'b0;
            fire_ff <= 1'b0;
        end else begin
            hit_ff  <= nxt_hit;
            fire_ff <= armed && nxt_hit && !hold && !fire_ff; // RQ14
        end
    end

endmodule

`default_nettype wire

// file: test/rtmr_top_props.sv
/* checker for rtmr_top: register port, timer and clock relations.
   assumes one core_clk domain, rst_n active low, bound by the bind below. */
`timescale 1ns/1ps
`default_nettype none
module rtmr_props #(parameter TICK_CYCLES = 4) (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata_ff,
    input wire logic [31:0] absolute_time_value_ff,
    input wire logic [2:0]  timer_status_ff,
    input wire logic        start_proceed_ff,
    input wire logic        action_started_interrupt_ff,
    input wire logic        timeout_event_ff
);
    // ====================
    // decodes
    wire       en_w  = reg_wr && reg_addr == 8'h40;
    wire       dis_w = reg_wr && reg_addr == 8'h44;
    wire       clk_w = reg_wr && reg_addr == 8'h48;
    wire       st_r  = reg_rd && (reg_addr == 8'h40 || reg_addr == 8'h44);
    wire [2:0] ts    = timer_status_ff;
    wire [2:0] off   = reg_wdata[2:0] | reg_wdata[5:3];
    wire       abrt  = dis_w && |(reg_wdata[5:3] & ts);
    wire [31:0] av   = absolute_time_value_ff;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ====================
    // properties
    property p_en; en_w |=> (ts & $past(reg_wdata[2:0])) == $past(reg_wdata[2:0]); endproperty
    property p_only; |(ts & ~$past(ts)) |-> $past(en_w); endproperty
    property p_dis; dis_w |=> (ts & $past(off)) == 3'h0; endproperty
    property p_rd_st; st_r |=> reg_rdata_ff == {29'h0, $past(ts)}; endproperty
    property p_to; abrt |=> timeout_event_ff; endproperty
    property p_to_src; timeout_event_ff |-> $past(abrt); endproperty
    property p_inc; av != $past(av) && !$past(clk_w) |-> av == $past(av) + 32'h1; endproperty
    property p_load; clk_w |=> av == $past(reg_wdata); endproperty
    property p_rd_clk; reg_rd && reg_addr == 8'h48 |=> reg_rdata_ff == $past(av); endproperty
    property p_start; start_proceed_ff |-> action_started_interrupt_ff && !ts[0]; endproperty
    a_en: assert property (p_en) else $error("enable write missed");
    a_only: assert property (p_only) else $error("timer armed without enable");
    a_dis: assert property (p_dis) else $error("disable write missed");
    a_rd_st: assert property (p_rd_st) else $error("status read wrong");
    a_to: assert property (p_to) else $error("timeout missing");
    a_to_src: assert property (p_to_src) else $error("timeout without abort");
    a_inc: assert property (p_inc) else $error("clock step wrong");
    a_load: assert property (p_load) else $error("clock load wrong");
    a_rd_clk: assert property (p_rd_clk) else $error("clock read wrong");
    a_start: assert property (p_start) else $error("start match wrong");
    c_abort: cover property (abrt ##1 timeout_event_ff);
    c_start: cover property (start_proceed_ff);
    c_load: cover property (clk_w);
endmodule
bind rtmr_top rtmr_props #(.TICK_CYCLES(TICK_CYCLES)) i_rtmr_props (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .absolute_time_value_ff(absolute_time_value_ff), .timer_status_ff(timer_status_ff),
    .start_proceed_ff(start_proceed_ff), .timeout_event_ff(timeout_event_ff),
    .action_started_interrupt_ff(action_started_interrupt_ff));
`default_nettype wire

// file: test/rtmr_top_tb.sv
/* self-checking bench for rtmr_top over its strobe register port.
   assumes TICK_CYCLES of 4 and the checker bound in. */
`timescale 1ns/1ps
`default_nettype none
module rtmr_top_tb;
    logic        core_clk, rst_n, reg_wr, reg_rd, rx_sfd_seen, rx_done;
    logic        proceed, cpl_ev, soft_ev, to_ev, asi, irq, s_to, s_asi;
    logic [7:0]  reg_addr;
    logic [2:0]  stat, s_stat, s_ev;
    logic [31:0] reg_wdata, rdata, abs_v, start_trigger, cpl_trigger, soft_trigger, rel_time;
    int          error_cnt = 0, total_checks = 0, cyc = 0;
    wire [2:0]   ev = {soft_ev, cpl_ev, proceed};

    rtmr_top #(.TICK_CYCLES(4)) i_rtmr_top (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rdata),
        .start_trigger(start_trigger), .cpl_trigger(cpl_trigger),
        .soft_trigger(soft_trigger), .rel_time(rel_time), .rx_sfd_seen(rx_sfd_seen),
        .rx_done(rx_done), .absolute_time_value_ff(abs_v), .timer_status_ff(stat),
        .start_proceed_ff(proceed), .cpl_event_ff(cpl_ev), .soft_event_ff(soft_ev),
        .timeout_event_ff(to_ev), .action_started_interrupt_ff(asi), .irq_ff(irq));

    // ====================
    // helpers
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic summarize;
        if (error_cnt == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
        s_to = to_ev;
        s_stat = stat;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check("read data", rdata, exp);
        @(posedge core_clk);
    endtask
    task automatic chk_irq(input logic exp);
        #1;
        check("irq", irq, exp);
        @(posedge core_clk);
    endtask
    task automatic wait_ev(input int i, input int lim);
        int n;
        n = 0;
        #1;
        while (ev[i] !== 1'b1 && n < lim) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        s_ev = ev;
        s_asi = asi;
        s_stat = stat;
        @(posedge core_clk);
    endtask

    // ====================
    // scenarios
    task automatic t_regs;
        rd(8'h40, 32'h0);
        wr(8'h40, 32'hffff_fff9);
        rd(8'h40, 32'h1);
        wr(8'h40, 32'h4);
        rd(8'h44, 32'h5);
        rd(8'h10, 32'h0);
        wr(8'h44, 32'h1);
        check("no timeout", s_to, 1'b0);
        rd(8'h44, 32'h4);
        wr(8'h44, 32'h20);
        check("abort timeout", s_to, 1'b1);
        check("abort status", s_stat, 3'h0);
        wr(8'h44, 32'h10);
        check("idle abort", s_to, 1'b0);
        wr(8'h40, 32'h7);
        wr(8'h44, 32'hffff_ffc2);
        rd(8'h40, 32'h5);
        wr(8'h44, 32'h7);
    endtask
    task automatic t_irq;
        wr(8'h60, 32'hf);
        wr(8'h64, 32'h2);
        chk_irq(1'b0);
        wr(8'h40, 32'h1);
        wr(8'h44, 32'h8);
        chk_irq(1'b1);
        wr(8'h60, 32'h2);
        chk_irq(1'b0);
        wr(8'h64, 32'h0);
        wr(8'h40, 32'h1);
        wr(8'h44, 32'h8);
        chk_irq(1'b0);
    endtask
    task automatic t_clock;
        logic [31:0] v;
        int n;
        wr(8'h48, 32'h1234_5678);
        rd(8'h48, 32'h1234_5678);
        for (int k = 0; k < 2; k++) begin
            v = abs_v;
            n = 0;
            while (abs_v === v && n < 20) begin
                @(posedge core_clk);
                #1;
                n++;
            end
        end
        check("tick gap", n, 4);
        check("tick step", abs_v, v + 32'h1);
        @(posedge core_clk);
    endtask
    task automatic t_match;
        wr(8'h48, 32'h100);
        wr(8'h40, 32'h1);
        wait_ev(0, 40);
        check("start fire", s_ev[0], 1'b1);
        check("started irq", s_asi, 1'b1);
        check("start off", s_stat[0], 1'b0);
        rel_time <= 32'h55;
        wr(8'h68, 32'h1);
        wr(8'h40, 32'h2);
        wait_ev(1, 40);
        check("rel match", s_ev[1], 1'b1);
        rx_sfd_seen <= 1'b1;
        repeat (4) @(posedge core_clk);
        wr(8'h40, 32'h4);
        wait_ev(2, 30);
        check("soft held", s_ev[2], 1'b0);
        rx_sfd_seen <= 1'b0;
        rx_done <= 1'b1;
        wait_ev(2, 30);
        check("soft released", s_ev[2], 1'b1);
        rx_done <= 1'b0;
        rd(8'h68, 32'h1);
        rd(8'h64, 32'h0);
        rd(8'h60, 32'hf);
    endtask

    // ====================
    // clock, watchdog, main
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            summarize;
        end
    end
    initial begin
        {reg_wr, reg_rd, rx_sfd_seen, rx_done} = 4'h0;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        start_trigger = 32'h102;
        cpl_trigger = 32'h55;
        soft_trigger = 32'h55;
        rel_time = 32'h0;
        rst_n = 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        t_regs;
        t_irq;
        t_clock;
        t_match;
        summarize;
    end
endmodule
`default_nettype wire
